//--- src/usart_pkg.sv
/*
  Constants, register map and mode type of the serial control unit.
  Assumes an 8-bit register port and an 8-bit baud divisor.
*/
package usart_pkg;

  // ------------------------------------------------------------------
  // Register offsets and reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_RX_STATUS_CONTROL = 8'h18;
  localparam logic [7:0] ADDR_TX_STATUS_CONTROL = 8'h98;
  localparam logic [7:0] ADDR_BAUD_DIVISOR      = 8'h99;
  localparam logic [7:0] TX_STATUS_RESET        = 8'h02;
  localparam logic [7:0] RX_STATUS_RESET        = 8'h00;
  localparam logic [7:0] BAUD_DIVISOR_RESET     = 8'h00;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int BIT_CLOCK_SOURCE    = 7;
  localparam int BIT_TX_NINE_ENABLE  = 6;
  localparam int BIT_TX_ENABLE       = 5;
  localparam int BIT_SYNC_MODE       = 4;
  localparam int BIT_HIGH_SPEED      = 2;
  localparam int BIT_SHIFT_EMPTY     = 1;
  localparam int BIT_TX_NINE         = 0;
  localparam int BIT_PORT_ENABLE     = 7;
  localparam int BIT_RX_NINE_ENABLE  = 6;
  localparam int BIT_SINGLE_RECEIVE  = 5;
  localparam int BIT_CONT_RECEIVE    = 4;
  localparam int BIT_FRAMING_ERROR   = 2;
  localparam int BIT_OVERRUN_ERROR   = 1;
  localparam int BIT_RX_NINE         = 0;

  // ------------------------------------------------------------------
  // Prescaler last phase and centre phase per mode
  // ------------------------------------------------------------------
  localparam logic [5:0] PHASE_LAST_ASYNC_LOW  = 6'h3F;
  localparam logic [5:0] PHASE_LAST_ASYNC_HIGH = 6'h0F;
  localparam logic [5:0] PHASE_LAST_SYNC       = 6'h03;
  localparam logic [5:0] PHASE_MID_ASYNC_LOW   = 6'h20;
  localparam logic [5:0] PHASE_MID_ASYNC_HIGH  = 6'h08;
  localparam logic [5:0] PHASE_MID_SYNC        = 6'h02;

  typedef enum logic [1:0] {
    MODE_ASYNC,
    MODE_SYNC_MASTER,
    MODE_SYNC_SLAVE
  } serial_mode_e;

endpackage

//--- src/baud_timer.sv
/*
  Baud timer with bit-rate prescaler.
  Assumes the divisor and prescale selection are stable registers.
*/
`timescale 1ns/1ps
module baud_timer import usart_pkg::*; #(
  parameter int DIVISOR_WIDTH = 8
) (
  input  wire logic                     mclk,
  input  wire logic                     rst,
  input  wire logic [DIVISOR_WIDTH-1:0] divisor,
  input  wire logic                     restart,
  input  wire logic [5:0]               phase_last,
  output logic                          baud_tick_q,
  output logic [5:0]                    phase_q,
  output logic                          bit_tick_q
);

  logic [DIVISOR_WIDTH-1:0] count_q;
  logic                     wrap;

  assign wrap = (count_q == divisor);

  always_ff @(posedge mclk) begin
    if (rst || restart) begin
      count_q <= '0;
    end else if (wrap) begin
      count_q <= '0;
    end else begin
      count_q <= count_q + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || restart) begin
      baud_tick_q <= 1'b0;
      phase_q     <= 6'h00;
      bit_tick_q  <= 1'b0;
    end else begin
      baud_tick_q <= wrap;
      bit_tick_q  <= wrap && (phase_q >= phase_last);
      if (wrap) begin
        phase_q <= (phase_q >= phase_last) ? 6'h00 : phase_q + 6'h01;
      end
    end
  end

endmodule

//--- src/majority_sampler.sv
/*
  Three-sample majority detector for the receive line.
  Assumes the line input is synchronous to mclk.
*/
`timescale 1ns/1ps
module majority_sampler import usart_pkg::*; (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       line_in,
  input  wire logic       baud_tick,
  input  wire logic [5:0] phase,
  input  wire logic [5:0] phase_mid,
  output logic            bit_valid_q,
  output logic            bit_level_q
);

  logic [1:0] early_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      early_q     <= 2'h0;
      bit_valid_q <= 1'b0;
      bit_level_q <= 1'b1;
    end else begin
      bit_valid_q <= 1'b0;
      if (baud_tick && phase == phase_mid - 6'h01) begin
        early_q[0] <= line_in;
      end
      if (baud_tick && phase == phase_mid) begin
        early_q[1] <= line_in;
      end
      if (baud_tick && phase == phase_mid + 6'h01) begin
        bit_valid_q <= 1'b1;
        bit_level_q <= (early_q[0] & early_q[1]) | (early_q[0] & line_in)
                     | (early_q[1] & line_in);
      end
    end
  end

endmodule

//--- src/usart_control_baud_generator.sv
/*
  Control, status, baud generation and receive sampling of the serial unit.
  Assumes external shift datapaths report their events as one-cycle pulses
  and that all pin inputs are synchronous to mclk.
*/
`timescale 1ns/1ps
module usart_control_baud_generator import usart_pkg::*; #(
  parameter int DIVISOR_WIDTH = 8
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  input  wire logic [1:0] port_c_direction,
  input  wire logic       tx_shift_empty,
  input  wire logic       tx_serial_data,
  input  wire logic       rx_char_done,
  input  wire logic       rx_frame_error,
  input  wire logic       rx_overrun,
  input  wire logic       rx_ninth_data,
  input  wire logic       sync_rx_done,
  input  wire logic       tx_clock_pin_in,
  output logic            tx_clock_pin_out,
  output logic            tx_clock_pin_oe,
  input  wire logic       rx_data_pin_in,
  output logic            rx_data_pin_out,
  output logic            rx_data_pin_oe,
  output logic [1:0]      serial_mode,
  output logic            serial_pins_active,
  output logic            tx_enable,
  output logic            rx_enable,
  output logic            tx_nine_bits,
  output logic            tx_bit_nine,
  output logic            rx_nine_bits,
  output logic            baud_tick,
  output logic            shift_tick,
  output logic            rx_bit_valid,
  output logic            rx_bit_level
);

  // ------------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------------
  logic                     clock_source_select_q;
  logic                     tx_nine_bit_enable_q;
  logic                     transmitter_enable_q;
  logic                     sync_select_q;
  logic                     high_speed_baud_select_q;
  logic                     shift_reg_empty_q;
  logic                     tx_bit_nine_q;
  logic                     serial_port_enable_q;
  logic                     rx_nine_bit_enable_q;
  logic                     single_receive_enable_q;
  logic                     continuous_receive_enable_q;
  logic                     framing_error_flag_q;
  logic                     overrun_error_flag_q;
  logic                     rx_bit_nine_q;
  logic [DIVISOR_WIDTH-1:0] baud_divisor_q;
  logic [7:0]               rdata_q;

  // ------------------------------------------------------------------
  // Derived control
  // ------------------------------------------------------------------
  logic                     wr_tx;
  logic                     wr_rx;
  logic                     wr_div;
  serial_mode_e             mode;
  logic                     pins_active;
  logic                     rx_on;
  logic                     tx_on;
  logic [5:0]               phase_last;
  logic [5:0]               phase_mid;
  logic                     baud_tick_w;
  logic [5:0]               phase_w;
  logic                     bit_tick_w;
  logic                     maj_valid_w;
  logic                     maj_level_w;
  logic                     ext_clock_prev_q;
  logic                     ext_rise_q;
  logic                     clock_out_q;
  logic                     shift_tick_q;
  logic                     rx_bit_valid_q;
  logic                     rx_bit_level_q;

  assign wr_tx  = reg_wr && (reg_addr == ADDR_TX_STATUS_CONTROL);
  assign wr_rx  = reg_wr && (reg_addr == ADDR_RX_STATUS_CONTROL);
  assign wr_div = reg_wr && (reg_addr == ADDR_BAUD_DIVISOR);

  always_comb begin
    if (!sync_select_q) begin
      mode = MODE_ASYNC;
    end else if (clock_source_select_q) begin
      mode = MODE_SYNC_MASTER;
    end else begin
      mode = MODE_SYNC_SLAVE;
    end
  end

  assign pins_active = serial_port_enable_q && (&port_c_direction);

  always_comb begin
    case (mode)
      MODE_ASYNC: begin
        rx_on = continuous_receive_enable_q;
      end
      MODE_SYNC_MASTER: begin
        rx_on = continuous_receive_enable_q || single_receive_enable_q;
      end
      MODE_SYNC_SLAVE: begin
        rx_on = continuous_receive_enable_q;
      end
      default: begin
        rx_on = 1'b0;
      end
    endcase
  end

  assign tx_on = serial_port_enable_q && transmitter_enable_q
               && !(sync_select_q && (single_receive_enable_q
               || continuous_receive_enable_q));

  always_comb begin
    case (mode)
      MODE_ASYNC: begin
        if (high_speed_baud_select_q) begin
          phase_last = PHASE_LAST_ASYNC_HIGH;
          phase_mid  = PHASE_MID_ASYNC_HIGH;
        end else begin
          phase_last = PHASE_LAST_ASYNC_LOW;
          phase_mid  = PHASE_MID_ASYNC_LOW;
        end
      end
      default: begin
        phase_last = PHASE_LAST_SYNC;
        phase_mid  = PHASE_MID_SYNC;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // Transmit status and control
  // ------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      clock_source_select_q    <= TX_STATUS_RESET[BIT_CLOCK_SOURCE];
      tx_nine_bit_enable_q     <= TX_STATUS_RESET[BIT_TX_NINE_ENABLE];
      transmitter_enable_q     <= TX_STATUS_RESET[BIT_TX_ENABLE];
      sync_select_q            <= TX_STATUS_RESET[BIT_SYNC_MODE];
      high_speed_baud_select_q <= TX_STATUS_RESET[BIT_HIGH_SPEED];
      tx_bit_nine_q            <= TX_STATUS_RESET[BIT_TX_NINE];
    end else if (wr_tx) begin
      clock_source_select_q    <= reg_wdata[BIT_CLOCK_SOURCE];
      tx_nine_bit_enable_q     <= reg_wdata[BIT_TX_NINE_ENABLE];
      transmitter_enable_q     <= reg_wdata[BIT_TX_ENABLE];
      sync_select_q            <= reg_wdata[BIT_SYNC_MODE];
      high_speed_baud_select_q <= reg_wdata[BIT_HIGH_SPEED];
      tx_bit_nine_q            <= reg_wdata[BIT_TX_NINE];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      shift_reg_empty_q <= TX_STATUS_RESET[BIT_SHIFT_EMPTY];
    end else begin
      shift_reg_empty_q <= tx_shift_empty;
    end
  end

  // ------------------------------------------------------------------
  // Receive status and control
  // ------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      serial_port_enable_q        <= RX_STATUS_RESET[BIT_PORT_ENABLE];
      rx_nine_bit_enable_q        <= RX_STATUS_RESET[BIT_RX_NINE_ENABLE];
      continuous_receive_enable_q <= RX_STATUS_RESET[BIT_CONT_RECEIVE];
    end else if (wr_rx) begin
      serial_port_enable_q        <= reg_wdata[BIT_PORT_ENABLE];
      rx_nine_bit_enable_q        <= reg_wdata[BIT_RX_NINE_ENABLE];
      continuous_receive_enable_q <= reg_wdata[BIT_CONT_RECEIVE];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      single_receive_enable_q <= RX_STATUS_RESET[BIT_SINGLE_RECEIVE];
    end else if (wr_rx) begin
      single_receive_enable_q <= reg_wdata[BIT_SINGLE_RECEIVE];
    end else if (mode == MODE_SYNC_MASTER && sync_rx_done
                 && !continuous_receive_enable_q) begin
      single_receive_enable_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      framing_error_flag_q <= RX_STATUS_RESET[BIT_FRAMING_ERROR];
      rx_bit_nine_q        <= RX_STATUS_RESET[BIT_RX_NINE];
    end else if (rx_char_done) begin
      framing_error_flag_q <= rx_frame_error;
      rx_bit_nine_q        <= rx_nine_bit_enable_q && rx_ninth_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      overrun_error_flag_q <= RX_STATUS_RESET[BIT_OVERRUN_ERROR];
    end else if (rx_overrun) begin
      overrun_error_flag_q <= 1'b1;
    end else if (!continuous_receive_enable_q) begin
      overrun_error_flag_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Baud divisor
  // ------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      baud_divisor_q <= BAUD_DIVISOR_RESET[DIVISOR_WIDTH-1:0];
    end else if (wr_div) begin
      baud_divisor_q <= reg_wdata[DIVISOR_WIDTH-1:0];
    end
  end

  // ------------------------------------------------------------------
  // Register read port
  // ------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_TX_STATUS_CONTROL: begin
          rdata_q <= {clock_source_select_q, tx_nine_bit_enable_q,
                      transmitter_enable_q, sync_select_q, 1'b0,
                      high_speed_baud_select_q, shift_reg_empty_q,
                      tx_bit_nine_q};
        end
        ADDR_RX_STATUS_CONTROL: begin
          rdata_q <= {serial_port_enable_q, rx_nine_bit_enable_q,
                      single_receive_enable_q,
                      continuous_receive_enable_q, 1'b0,
                      framing_error_flag_q, overrun_error_flag_q,
                      rx_bit_nine_q};
        end
        ADDR_BAUD_DIVISOR: begin
          rdata_q <= 8'(baud_divisor_q);
        end
        default: begin
          rdata_q <= 8'h00;
        end
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // ------------------------------------------------------------------
  // Baud generation and sampling
  // ------------------------------------------------------------------
  baud_timer #(
    .DIVISOR_WIDTH (DIVISOR_WIDTH)
  ) u_baud_timer (
    .mclk        (mclk),
    .rst         (rst),
    .divisor     (baud_divisor_q),
    .restart     (wr_div),
    .phase_last  (phase_last),
    .baud_tick_q (baud_tick_w),
    .phase_q     (phase_w),
    .bit_tick_q  (bit_tick_w)
  );

  majority_sampler u_majority_sampler (
    .mclk        (mclk),
    .rst         (rst),
    .line_in     (rx_data_pin_in),
    .baud_tick   (baud_tick_w),
    .phase       (phase_w),
    .phase_mid   (phase_mid),
    .bit_valid_q (maj_valid_w),
    .bit_level_q (maj_level_w)
  );

  always_ff @(posedge mclk) begin
    if (rst) begin
      ext_clock_prev_q <= 1'b1;
      ext_rise_q       <= 1'b0;
    end else begin
      ext_clock_prev_q <= tx_clock_pin_in;
      ext_rise_q       <= tx_clock_pin_in && !ext_clock_prev_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      clock_out_q <= 1'b1;
    end else begin
      clock_out_q <= !phase_w[1];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      shift_tick_q   <= 1'b0;
      rx_bit_valid_q <= 1'b0;
      rx_bit_level_q <= 1'b1;
    end else begin
      case (mode)
        MODE_ASYNC: begin
          shift_tick_q   <= bit_tick_w;
          rx_bit_valid_q <= maj_valid_w && rx_on && pins_active;
          rx_bit_level_q <= maj_level_w;
        end
        MODE_SYNC_MASTER: begin
          shift_tick_q   <= bit_tick_w;
          rx_bit_valid_q <= bit_tick_w && rx_on && pins_active;
          rx_bit_level_q <= rx_data_pin_in;
        end
        default: begin
          shift_tick_q   <= ext_rise_q;
          rx_bit_valid_q <= ext_rise_q && rx_on && pins_active;
          rx_bit_level_q <= rx_data_pin_in;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------------
  always_comb begin
    tx_clock_pin_out = 1'b1;
    tx_clock_pin_oe  = 1'b0;
    rx_data_pin_out  = 1'b1;
    rx_data_pin_oe   = 1'b0;
    case (mode)
      MODE_ASYNC: begin
        tx_clock_pin_out = tx_serial_data;
        tx_clock_pin_oe  = pins_active && tx_on;
      end
      MODE_SYNC_MASTER: begin
        tx_clock_pin_out = clock_out_q;
        tx_clock_pin_oe  = pins_active && (tx_on || rx_on);
        rx_data_pin_out  = tx_serial_data;
        rx_data_pin_oe   = pins_active && tx_on;
      end
      default: begin
        rx_data_pin_out  = tx_serial_data;
        rx_data_pin_oe   = pins_active && tx_on;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign reg_rdata          = rdata_q;
  assign serial_mode        = mode;
  assign serial_pins_active = pins_active;
  assign tx_enable          = tx_on && pins_active;
  assign rx_enable          = rx_on && pins_active;
  assign tx_nine_bits       = tx_nine_bit_enable_q;
  assign tx_bit_nine        = tx_bit_nine_q;
  assign rx_nine_bits       = rx_nine_bit_enable_q;
  assign baud_tick          = baud_tick_w;
  assign shift_tick         = shift_tick_q;
  assign rx_bit_valid       = rx_bit_valid_q;
  assign rx_bit_level       = rx_bit_level_q;

endmodule

//--- verification/usart_ctrl_checker.sv
/* Port assertions for the serial control unit.
   Assumes it is bound to the top module and sees its ports. */
`timescale 1ns/1ps
module usart_ctrl_checker import usart_pkg::*; (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [1:0] port_c_direction,
  input wire logic       rx_overrun,
  input wire logic       tx_clock_pin_in,
  input wire logic       tx_clock_pin_oe,
  input wire logic       rx_data_pin_oe,
  input wire logic [1:0] serial_mode,
  input wire logic       serial_pins_active,
  input wire logic       tx_enable,
  input wire logic       rx_enable,
  input wire logic       baud_tick,
  input wire logic       shift_tick
);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  AST_BIT3_ZERO: assert property (reg_rd |=> !reg_rdata[3])
    else $error("bit 3 reads one");
  AST_PINS_DIR: assert property (port_c_direction != 2'h3
    |-> !serial_pins_active) else $error("pins active without direction");
  AST_PINS_OE: assert property (!serial_pins_active
    |-> !tx_clock_pin_oe && !rx_data_pin_oe) else $error("pin driven");
  AST_DIV_READBACK: assert property ((reg_wr && reg_addr ==
    ADDR_BAUD_DIVISOR) ##1 (reg_rd && reg_addr == ADDR_BAUD_DIVISOR)
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("divisor readback");
  AST_BAUD_RESTART: assert property (reg_wr && reg_wdata == 8'h03 &&
    reg_addr == ADDR_BAUD_DIVISOR |=> ##1 !baud_tick [*2] ##[1:6] baud_tick)
    else $error("baud timer not restarted");
  AST_OVERRUN_SET: assert property (rx_overrun ##1 (reg_rd &&
    reg_addr == ADDR_RX_STATUS_CONTROL) |=> reg_rdata[1])
    else $error("overrun flag not set");
  AST_TX_OVERRIDE: assert property (serial_mode != 2'h0 && rx_enable
    |-> !tx_enable) else $error("transmit not overridden");
  AST_SLAVE_NO_CLK: assert property (serial_mode == 2'h2
    |-> !tx_clock_pin_oe) else $error("slave drives clock pin");
  AST_SLAVE_SHIFT: assert property (serial_mode == 2'h2 &&
    serial_pins_active && $rose(tx_clock_pin_in) |-> ##[1:3] shift_tick)
    else $error("slave shift clock missing");
  cover property (baud_tick ##1 baud_tick);
  cover property (rx_overrun ##1 reg_rd);
  cover property (serial_mode == 2'h2 && shift_tick);
endmodule
bind usart_control_baud_generator usart_ctrl_checker i_chk (.mclk, .rst,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .port_c_direction,
  .rx_overrun, .tx_clock_pin_in, .tx_clock_pin_oe, .rx_data_pin_oe,
  .serial_mode, .serial_pins_active, .tx_enable, .rx_enable, .baud_tick,
  .shift_tick);

//--- verification/serial_far_end.sv
/* Far-end serial peer: external shift clock and data line.
   Assumes the bench resolves pins from the output enables. */
`timescale 1ns/1ps
module serial_far_end (
  input  wire logic mclk,
  input  wire logic clk_run,
  input  wire logic data_level,
  output logic      ext_clock_q,
  output logic      data_line
);
  // ----------------------------------------------------------------
  // Clock runs only within frames, period 8 mclk, rests low.
  // ----------------------------------------------------------------
  logic [1:0] div_q;
  always_ff @(posedge mclk) begin
    if (!clk_run) begin
      div_q       <= 2'h0;
      ext_clock_q <= 1'b0;
    end else begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h3) ext_clock_q <= !ext_clock_q;
    end
  end
  assign data_line = data_level;
endmodule

//--- verification/usart_control_baud_generator_test.sv
/* Self-checking bench of the serial control unit.
   Assumes the far-end peer model and the bound checker. */
`timescale 1ns/1ps
module usart_control_baud_generator_test import usart_pkg::*; ;
  logic       mclk, rst, reg_wr, reg_rd, tx_shift_empty, tx_serial_data;
  logic       rx_char_done, rx_frame_error, rx_overrun, rx_ninth_data;
  logic       sync_rx_done, tx_clock_pin_in, tx_clock_pin_out, v;
  logic       tx_clock_pin_oe, rx_data_pin_in, rx_data_pin_out;
  logic       rx_data_pin_oe, serial_pins_active, tx_enable, rx_enable;
  logic       tx_nine_bits, tx_bit_nine, rx_nine_bits, baud_tick;
  logic       shift_tick, rx_bit_valid, rx_bit_level, clk_run;
  logic       data_level, ext_clock_q, data_line;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, seen;
  logic [1:0] port_c_direction, serial_mode;
  int         err_total, n_checks, c, c2;
  assign tx_clock_pin_in = tx_clock_pin_oe ? tx_clock_pin_out : ext_clock_q;
  assign rx_data_pin_in  = rx_data_pin_oe ? rx_data_pin_out : data_line;
  usart_control_baud_generator i_dut (.mclk, .rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .port_c_direction, .tx_shift_empty,
    .tx_serial_data, .rx_char_done, .rx_frame_error, .rx_overrun,
    .rx_ninth_data, .sync_rx_done, .tx_clock_pin_in, .tx_clock_pin_out,
    .tx_clock_pin_oe, .rx_data_pin_in, .rx_data_pin_out, .rx_data_pin_oe,
    .serial_mode, .serial_pins_active, .tx_enable, .rx_enable,
    .tx_nine_bits, .tx_bit_nine, .rx_nine_bits, .baud_tick, .shift_tick,
    .rx_bit_valid, .rx_bit_level);
  serial_far_end i_far (.mclk, .clk_run, .data_level, .ext_clock_q,
    .data_line);
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 seen = reg_rdata;
  endtask
  task count(input bit sh, input int n, output int k);
    k = 0;
    repeat (n) begin
      @(posedge mclk);
      #1 k += int'(sh ? shift_tick === 1'b1 : baud_tick === 1'b1);
    end
  endtask
  task wait_valid();
    v = 1'b0;
    for (int k = 0; k < 100 && !v; k++) begin
      @(posedge mclk);
      #1 v = (rx_bit_valid === 1'b1);
    end
  endtask
  task tally_and_finish();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_regs();
    rd(ADDR_TX_STATUS_CONTROL);
    chk("tx reset", seen, 8'h02);
    rd(ADDR_RX_STATUS_CONTROL);
    chk("rx reset", seen & 8'hFE, 8'h00);
    rd(8'h55);
    chk("unmapped", seen, 8'h00);
    wr(ADDR_TX_STATUS_CONTROL, 8'hFF);
    chk("nine bits", {5'h0, rx_nine_bits, tx_nine_bits, tx_bit_nine},
        8'h03);
    rd(ADDR_TX_STATUS_CONTROL);
    chk("tx ones", seen, 8'hF7);
    tx_shift_empty <= 1'b0;
    rd(ADDR_TX_STATUS_CONTROL);
    chk("tx busy", seen, 8'hF5);
    tx_shift_empty <= 1'b1;
    wr(ADDR_TX_STATUS_CONTROL, 8'h00);
    wr(ADDR_RX_STATUS_CONTROL, 8'hFF);
    rd(ADDR_RX_STATUS_CONTROL);
    chk("rx ones", seen, 8'hF0);
  endtask
  task t_modes();
    logic [7:0] tv [4];
    logic [7:0] mv [4];
    tv = '{8'h00, 8'h90, 8'h10, 8'h84};
    mv = '{8'h00, 8'h01, 8'h02, 8'h00};
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_TX_STATUS_CONTROL, tv[i]);
      chk("mode", {6'h0, serial_mode}, mv[i]);
    end
    wr(ADDR_RX_STATUS_CONTROL, 8'h80);
    chk("pins on", {7'h0, serial_pins_active}, 8'h01);
    port_c_direction <= 2'h2;
    #4 chk("pins dir", {7'h0, serial_pins_active}, 8'h00);
    port_c_direction <= 2'h3;
    wr(ADDR_RX_STATUS_CONTROL, 8'h00);
    chk("pins off", {7'h0, serial_pins_active}, 8'h00);
  endtask
  task t_override();
    wr(ADDR_RX_STATUS_CONTROL, 8'h80);
    wr(ADDR_TX_STATUS_CONTROL, 8'hB0);
    chk("tx on", {7'h0, tx_enable}, 8'h01);
    wr(ADDR_RX_STATUS_CONTROL, 8'hA0);
    chk("tx off", {6'h0, tx_enable, rx_enable}, 8'h01);
    sync_rx_done <= 1'b1;
    @(posedge mclk);
    sync_rx_done <= 1'b0;
    rd(ADDR_RX_STATUS_CONTROL);
    chk("single done", seen, 8'h80);
    wr(ADDR_RX_STATUS_CONTROL, 8'h90);
    chk("continuous", {6'h0, tx_enable, rx_enable}, 8'h01);
    wr(ADDR_TX_STATUS_CONTROL, 8'h00);
  endtask
  task t_errors();
    wr(ADDR_RX_STATUS_CONTROL, 8'hD0);
    {rx_char_done, rx_frame_error, rx_ninth_data} <= 3'h7;
    @(posedge mclk);
    rx_char_done <= 1'b0;
    rx_overrun   <= 1'b1;
    @(posedge mclk);
    rx_overrun <= 1'b0;
    reg_addr   <= ADDR_RX_STATUS_CONTROL;
    reg_rd     <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk("flags", reg_rdata, 8'hD7);
    wr(ADDR_RX_STATUS_CONTROL, 8'hC0);
    rd(ADDR_RX_STATUS_CONTROL);
    chk("overrun clear", seen, 8'hC5);
    wr(ADDR_RX_STATUS_CONTROL, 8'h80);
  endtask
  task t_rates();
    logic [7:0] tv [4];
    int         mv [4];
    tv = '{8'h90, 8'h94, 8'h04, 8'h00};
    mv = '{4, 4, 16, 64};
    reg_addr  <= ADDR_BAUD_DIVISOR;
    reg_wdata <= 8'h03;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk("divisor", reg_rdata, 8'h03);
    count(1'b0, 40, c);
    chk("baud ticks", 8'(c), 8'h0A);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_TX_STATUS_CONTROL, tv[i]);
      count(1'b1, 4 * mv[i], c);
      count(1'b1, 16 * mv[i], c);
      chk("bit clocks", 8'(c), 8'h04);
    end
  endtask
  task t_slave();
    wr(ADDR_TX_STATUS_CONTROL, 8'h10);
    clk_run <= 1'b1;
    count(1'b1, 80, c);
    clk_run <= 1'b0;
    count(1'b1, 5, c2);
    chk("slave shifts", 8'(c + c2), 8'(80 / 8));
  endtask
  task t_sample();
    wr(ADDR_TX_STATUS_CONTROL, 8'h04);
    wr(ADDR_BAUD_DIVISOR, 8'h00);
    wr(ADDR_RX_STATUS_CONTROL, 8'h90);
    for (int i = 0; i < 2; i++) begin
      data_level <= 1'(i);
      wait_valid();
      wait_valid();
      chk("bit level", {6'h0, v, rx_bit_level}, {7'h1, 1'(i)});
    end
  endtask
  initial begin
    {rst, tx_shift_empty, data_level} = 3'h7;
    {reg_wr, reg_rd, tx_serial_data, rx_char_done, rx_frame_error} = 5'h0;
    {rx_overrun, rx_ninth_data, sync_rx_done, clk_run} = 4'h0;
    {reg_addr, reg_wdata, port_c_direction} = 18'h3;
    {err_total, n_checks} = 0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_modes();
    t_override();
    t_errors();
    t_rates();
    t_slave();
    t_sample();
    tally_and_finish();
  end
  initial begin
    #100000;
    err_total++;
    tally_and_finish();
  end
endmodule
